// ---- common/tcs_cfg.svh ----
// register offsets, field positions, reset values for the timer channel
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
`define TCS_OFF_CTRL 8'h00
`define TCS_OFF_MODE 8'h04
`define TCS_OFF_COUNT 8'h10
`define TCS_OFF_LAT_A 8'h14
`define TCS_OFF_LAT_B 8'h18
`define TCS_OFF_PER_C 8'h1C
`define TCS_OFF_STATUS 8'h20
`define TCS_CTRL_CLK_EN 0
`define TCS_CTRL_CLK_DIS 1
`define TCS_CTRL_SOFT_TRIG 2
`define TCS_ST_WRAP 0
`define TCS_ST_OVERWRITE 1
`define TCS_ST_MATCH_A 2
`define TCS_ST_MATCH_B 3
`define TCS_ST_MATCH_C 4
`define TCS_ST_LATCH_A 5
`define TCS_ST_LATCH_B 6
`define TCS_ST_EXT_TRIG 7
`define TCS_ST_CLK_ON 16
`define TCS_ST_LINE_A 17
`define TCS_ST_LINE_B 18
`define TCS_CNT_MAX 16'hFFFF
`define TCS_VAL_RST 16'h0000
`define TCS_MODE_RST 10'h000
`define TCS_RESP_OKAY 2'h0
`define TCS_RESP_SLVERR 2'h2
`endif

// ---- common/tcs_pkg.sv ----
// types for the timer channel status and compare block
package tcs_pkg;
   // line action codes: keep, drive high, drive low, invert
   typedef enum logic [1:0] {TCS_ACT_NONE, TCS_ACT_SET, TCS_ACT_CLR, TCS_ACT_TGL} tcs_act_e;
   // channel mode register layout
   typedef struct packed {
      tcs_act_e line_b_on_soft_trigger; // bits 9:8
      tcs_act_e line_b_on_ext_event;    // bits 7:6
      tcs_act_e line_b_on_match_c;      // bits 5:4
      logic [1:0] spare;                // bits 3:2
      logic reset_on_c;                 // bit 1
      logic pulse_output_select;        // bit 0, 1 = waveform
   } tcs_mode_s;
   // whole state of the channel
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] lat_a;
      logic [15:0] lat_b;
      logic [15:0] per_c;
      logic [7:0] flags;
      logic clk_on;
      logic line_a_o;
      logic line_b_o;
      tcs_mode_s mode;
      logic [1:0] a_sync;
      logic [1:0] b_sync;
      logic [1:0] e_sync;
      logic a_prev;
      logic e_prev;
      logic unread_a;
      logic unread_b;
      logic aw_have;
      logic [7:0] awaddr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tcs_state_s;
endpackage

// ---- hw/tcs_timer_channel.sv ----
// one timer channel: counter, latches, period compare, status, axi4-lite slave
// Function
// - on count equal to period value, act on line B per line_b_on_match_c, waveform mode only
// - on external event, act on line B per line_b_on_ext_event, waveform mode only
// - on software trigger, act on line B per line_b_on_soft_trigger, waveform mode only
// - live count register is read-only, low 16 bits, upper bits zero
// - latch A read-only in capture mode, read/write in waveform mode
// - latch B read-only in capture mode, read/write in waveform mode
// - period value always readable and writable
// - wrap flag set on counter overflow, cleared by status read
// - overwrite flag on second latch load without read, capture mode only
// - match A flag in waveform mode only, clears on status read
// - match B flag in waveform mode only, clears on status read
// - match C flag in both modes, clears on status read
// - latch A flag on latch A load, capture mode only
// - latch B flag on latch B load, capture mode only
// - external trigger flag set on each trigger, cleared by status read
// - status bit 16 shows counter clock enabled
// - status bit 17 mirrors line A: sensed in capture, driven in waveform
// - status bit 18 mirrors line B: sensed in capture, driven in waveform
// - pulse_output_select 0 means capture mode, 1 waveform mode
`timescale 1ns/100ps
`include "tcs_cfg.svh"
module tcs_timer_channel
   import tcs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer_line_a_i,
   output logic timer_line_a_o,
   output logic timer_line_a_oe,
   input wire logic timer_line_b_i,
   output logic timer_line_b_o,
   output logic timer_line_b_oe,
   input wire logic ext_event_i
);

   tcs_state_s s_q;
   tcs_state_s s_d;
   logic wave;
   logic running;
   logic match_a;
   logic match_b;
   logic match_c;
   logic ev_wrap;
   logic ev_ext;
   logic ev_soft;
   logic load_a;
   logic load_b;
   logic wr_go;
   logic rd_go;
   logic rd_status;
   logic [31:0] status_view;
   logic [31:0] rd_word;
   logic [15:0] mode_wr;

   // apply one action code to a line level
   function automatic logic line_act(input tcs_act_e code, input logic cur);
      case (code)
         TCS_ACT_SET: line_act = 1'b1;
         TCS_ACT_CLR: line_act = 1'b0;
         TCS_ACT_TGL: line_act = ~cur;
         default: line_act = cur;
      endcase
   endfunction

   // byte-lane merge of a 16-bit value
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
      merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction

   // event decode from the registered state
   always_comb begin
      wave = s_q.mode.pulse_output_select;
      running = s_q.clk_on;
      match_a = wave && running && (s_q.count == s_q.lat_a);
      match_b = wave && running && (s_q.count == s_q.lat_b);
      match_c = running && (s_q.count == s_q.per_c);
      ev_wrap = running && (s_q.count == `TCS_CNT_MAX);
      ev_ext = s_q.e_sync[1] && !s_q.e_prev; // rising edge of the event pin
      load_a = !wave && s_q.a_sync[1] && !s_q.a_prev; // capture on line A rise
      load_b = !wave && !s_q.a_sync[1] && s_q.a_prev; // capture on line A fall
      wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
      ev_soft = wr_go && (s_q.awaddr == `TCS_OFF_CTRL) && s_q.wstrb[0]
                && s_q.wdata[`TCS_CTRL_SOFT_TRIG];
      rd_go = s_axi_arvalid && !s_q.rvalid;
      rd_status = rd_go && (s_axi_araddr == `TCS_OFF_STATUS);
      mode_wr = merge16({6'h00, s_q.mode}, s_q.wdata, s_q.wstrb); // lanes merged, top cut
   end

   // status word with mode masking and line mirrors
   always_comb begin
      status_view = 32'h00000000;
      status_view[7:0] = s_q.flags;
      if (wave) begin
         status_view[`TCS_ST_OVERWRITE] = 1'b0;
         status_view[`TCS_ST_LATCH_A] = 1'b0;
         status_view[`TCS_ST_LATCH_B] = 1'b0;
      end else begin
         status_view[`TCS_ST_MATCH_A] = 1'b0;
         status_view[`TCS_ST_MATCH_B] = 1'b0;
      end
      status_view[`TCS_ST_CLK_ON] = s_q.clk_on;
      status_view[`TCS_ST_LINE_A] = wave ? s_q.line_a_o : s_q.a_sync[1];
      status_view[`TCS_ST_LINE_B] = wave ? s_q.line_b_o : s_q.b_sync[1];
   end

   // read data mux
   always_comb begin
      case (s_axi_araddr)
         `TCS_OFF_CTRL: rd_word = 32'h00000000;
         `TCS_OFF_MODE: rd_word = {22'h000000, s_q.mode};
         `TCS_OFF_COUNT: rd_word = {16'h0000, s_q.count};
         `TCS_OFF_LAT_A: rd_word = {16'h0000, s_q.lat_a};
         `TCS_OFF_LAT_B: rd_word = {16'h0000, s_q.lat_b};
         `TCS_OFF_PER_C: rd_word = {16'h0000, s_q.per_c};
         `TCS_OFF_STATUS: rd_word = status_view;
         default: rd_word = 32'h00000000;
      endcase
   end

   // next-state of the whole channel
   always_comb begin
      s_d = s_q;
      // pin synchronisers, second stage feeds edge detect
      s_d.a_sync = {s_q.a_sync[0], timer_line_a_i};
      s_d.b_sync = {s_q.b_sync[0], timer_line_b_i};
      s_d.e_sync = {s_q.e_sync[0], ext_event_i};
      s_d.a_prev = s_q.a_sync[1];
      s_d.e_prev = s_q.e_sync[1];
      // counter runs while enabled, wraps or restarts on period
      if (running) begin
         if (match_c && s_q.mode.reset_on_c) begin
            s_d.count = `TCS_VAL_RST;
         end else begin
            s_d.count = 16'(s_q.count + 16'h0001);
         end
      end
      // capture loads, overwrite tracking
      if (load_a) begin
         s_d.lat_a = s_q.count;
         s_d.unread_a = 1'b1;
      end
      if (load_b) begin
         s_d.lat_b = s_q.count;
         s_d.unread_b = 1'b1;
      end
      // waveform line A: high on match A, low on match C
      if (wave && match_a) begin
         s_d.line_a_o = 1'b1;
      end
      if (wave && match_c) begin
         s_d.line_a_o = 1'b0;
      end
      // line B actions applied in turn, each on the previous result: match C, event, software
      if (wave) begin
         if (match_c) begin
            s_d.line_b_o = line_act(s_q.mode.line_b_on_match_c, s_d.line_b_o);
         end
         if (ev_ext) begin
            s_d.line_b_o = line_act(s_q.mode.line_b_on_ext_event, s_d.line_b_o);
         end
         if (ev_soft) begin
            s_d.line_b_o = line_act(s_q.mode.line_b_on_soft_trigger, s_d.line_b_o);
         end
      end
      // axi write channel capture
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      // register write once address and data are both held
      if (wr_go) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `TCS_RESP_OKAY;
         case (s_q.awaddr)
            `TCS_OFF_CTRL: begin
               if (s_q.wstrb[0] && s_q.wdata[`TCS_CTRL_CLK_EN]) begin
                  s_d.clk_on = 1'b1;
               end
               if (s_q.wstrb[0] && s_q.wdata[`TCS_CTRL_CLK_DIS]) begin
                  s_d.clk_on = 1'b0; // disable beats enable
               end
            end
            `TCS_OFF_MODE: s_d.mode = tcs_mode_s'(mode_wr[9:0]);
            `TCS_OFF_LAT_A: begin
               if (wave) begin
                  s_d.lat_a = merge16(s_q.lat_a, s_q.wdata, s_q.wstrb);
               end
            end
            `TCS_OFF_LAT_B: begin
               if (wave) begin
                  s_d.lat_b = merge16(s_q.lat_b, s_q.wdata, s_q.wstrb);
               end
            end
            `TCS_OFF_PER_C: s_d.per_c = merge16(s_q.per_c, s_q.wdata, s_q.wstrb);
            `TCS_OFF_COUNT, `TCS_OFF_STATUS: s_d.bresp = `TCS_RESP_OKAY; // writes ignored
            default: s_d.bresp = `TCS_RESP_SLVERR;
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // axi read, data registered one cycle after acceptance
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (rd_go) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_word;
         s_d.rresp = `TCS_RESP_OKAY;
         case (s_axi_araddr)
            `TCS_OFF_CTRL, `TCS_OFF_MODE, `TCS_OFF_COUNT, `TCS_OFF_PER_C,
            `TCS_OFF_STATUS: s_d.rresp = `TCS_RESP_OKAY;
            `TCS_OFF_LAT_A: s_d.unread_a = load_a; // read consumes, new load stays
            `TCS_OFF_LAT_B: s_d.unread_b = load_b;
            default: s_d.rresp = `TCS_RESP_SLVERR;
         endcase
      end
      // status read clears, events of the same cycle survive
      if (rd_status) begin
         s_d.flags = 8'h00;
      end
      if (ev_wrap) begin
         s_d.flags[`TCS_ST_WRAP] = 1'b1;
      end
      if ((load_a && s_q.unread_a) || (load_b && s_q.unread_b)) begin
         s_d.flags[`TCS_ST_OVERWRITE] = 1'b1;
      end
      if (match_a) begin
         s_d.flags[`TCS_ST_MATCH_A] = 1'b1;
      end
      if (match_b) begin
         s_d.flags[`TCS_ST_MATCH_B] = 1'b1;
      end
      if (match_c) begin
         s_d.flags[`TCS_ST_MATCH_C] = 1'b1;
      end
      if (load_a) begin
         s_d.flags[`TCS_ST_LATCH_A] = 1'b1;
      end
      if (load_b) begin
         s_d.flags[`TCS_ST_LATCH_B] = 1'b1;
      end
      if (ev_ext) begin
         s_d.flags[`TCS_ST_EXT_TRIG] = 1'b1;
      end
   end

   // single state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // bus and pin outputs
   assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
   assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign timer_line_a_o = s_q.line_a_o;
   assign timer_line_a_oe = wave;
   assign timer_line_b_o = s_q.line_b_o;
   assign timer_line_b_oe = wave;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_wrap_flag_set: assert property (ev_wrap |=> s_q.flags[0])
      else $error("wrap flag not set after overflow");
   chk_wrap_flag_clear: assert property (rd_status && !ev_wrap |=> !s_q.flags[0])
      else $error("wrap flag survived status read");
   chk_read_set_wins: assert property (rd_status && match_c |=> s_q.flags[4])
      else $error("match C event lost on status read");
   chk_count_advance: assert property (running && !match_c
      |=> s_q.count == 16'($past(s_q.count) + 16'h0001))
      else $error("counter did not advance");
   chk_lat_a_locked: assert property (wr_go && s_q.awaddr == `TCS_OFF_LAT_A && !wave
      && !load_a |=> $stable(s_q.lat_a))
      else $error("latch A written in capture mode");
   chk_lat_b_locked: assert property (wr_go && s_q.awaddr == `TCS_OFF_LAT_B && !wave
      && !load_b |=> $stable(s_q.lat_b))
      else $error("latch B written in capture mode");
   chk_per_c_write: assert property (wr_go && s_q.awaddr == `TCS_OFF_PER_C
      && s_q.wstrb == 4'hF |=> s_q.per_c == $past(s_q.wdata[15:0]))
      else $error("period value not written");
   chk_soft_set_b: assert property (wave && ev_soft
      && s_q.mode.line_b_on_soft_trigger == TCS_ACT_SET |=> s_q.line_b_o)
      else $error("soft trigger did not drive line B high");
   chk_ext_clr_b: assert property (wave && ev_ext && !ev_soft
      && s_q.mode.line_b_on_ext_event == TCS_ACT_CLR |=> !s_q.line_b_o)
      else $error("external event did not drive line B low");
   chk_match_c_tgl: assert property (wave && match_c && !ev_ext && !ev_soft
      && s_q.mode.line_b_on_match_c == TCS_ACT_TGL
      |=> s_q.line_b_o != $past(s_q.line_b_o))
      else $error("match C did not invert line B");
   chk_overwrite: assert property (load_a && s_q.unread_a |=> s_q.flags[1])
      else $error("overwrite not flagged");
   chk_mode_mask: assert property (rd_status && !wave |=> s_q.rdata[3:2] == 2'h0)
      else $error("compare flags visible in capture mode");
   chk_clk_mirror: assert property (rd_status
      |=> s_q.rvalid && s_q.rdata[16] == $past(s_q.clk_on))
      else $error("clock status mirror wrong");
   chk_line_b_mirror: assert property (rd_status && wave
      |=> s_q.rdata[18] == $past(s_q.line_b_o))
      else $error("line B mirror wrong");

   cov_wrap: cover property (ev_wrap ##1 rd_status);
   cov_overwrite: cover property (load_b && s_q.unread_b);
   cov_soft_trigger: cover property (wave && ev_soft);
   cov_write_done: cover property (s_q.bvalid && s_axi_bready);

endmodule // tcs_timer_channel

// ---- dv/tcs_tb.sv ----
// self-checking bench for the timer channel block
`timescale 1ns/100ps
`include "tcs_cfg.svh"
module tb;
   import tcs_pkg::*;
   logic aclk, aresetn;
   logic [7:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic line_a_i, line_b_i, ext_ev, line_a_o, line_a_oe, line_b_o, line_b_oe;
   int fail_count = 0;
   int n_compared = 0;

   // device under test, all strobes on
   tcs_timer_channel dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timer_line_a_i(line_a_i), .timer_line_a_o(line_a_o),
      .timer_line_a_oe(line_a_oe), .timer_line_b_i(line_b_i), .timer_line_b_o(line_b_o),
      .timer_line_b_oe(line_b_oe), .ext_event_i(ext_ev));

   // 50 mhz clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      rs = bresp;
   endtask

   // read: result left in rd and rs
   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
   endtask

   function automatic logic [31:0] md(logic wave, logic rc, logic [1:0] mc, logic [1:0] ev,
                                      logic [1:0] sw);
      return {22'h0, sw, ev, mc, 2'b00, rc, wave};
   endfunction

   // expected line level after one action code
   function automatic logic nxt(logic cur, logic [1:0] c);
      case (c)
         2'h1: return 1'b1;
         2'h2: return 1'b0;
         2'h3: return ~cur;
         default: return cur;
      endcase
   endfunction

   task automatic t_regs();
      rdr(`TCS_OFF_STATUS);
      chk(rd & 32'h0007_00FF, 32'h0);
      wr(`TCS_OFF_PER_C, 32'hABCD1234);
      rdr(`TCS_OFF_PER_C);
      chk(rd, 32'h0000_1234);
      wr(`TCS_OFF_LAT_A, 32'h5A5A);
      rdr(`TCS_OFF_LAT_A);
      chk(rd, 32'h0);
      wr(`TCS_OFF_LAT_B, 32'hA5A5);
      rdr(`TCS_OFF_LAT_B);
      chk(rd, 32'h0);
      wr(`TCS_OFF_MODE, md(1'b1, 1'b0, 2'h0, 2'h0, 2'h0));
      wr(`TCS_OFF_LAT_A, 32'h5A5A);
      rdr(`TCS_OFF_LAT_A);
      chk(rd, 32'h5A5A);
      wr(`TCS_OFF_LAT_B, 32'hA5A5);
      rdr(`TCS_OFF_LAT_B);
      chk(rd, 32'hA5A5);
      wr(`TCS_OFF_COUNT, 32'h7777);
      rdr(`TCS_OFF_COUNT);
      chk(rd, 32'h0);
      wr(8'h30, 32'h1);
      chk(rs, `TCS_RESP_SLVERR);
      rdr(8'h30);
      chk(rd, 32'h0);
      chk(rs, `TCS_RESP_SLVERR);
   endtask

   // soft trigger or external event acting on line b, every code
   task automatic t_trig(input logic use_ext);
      logic [1:0] codes [5] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h3};
      logic exp;
      exp = line_b_o;
      foreach (codes[i]) begin
         if (use_ext) begin
            wr(`TCS_OFF_MODE, md(1'b1, 1'b0, 2'h0, codes[i], 2'h0));
            ext_ev <= 1'b1;
            tick(3);
            ext_ev <= 1'b0;
         end else begin
            wr(`TCS_OFF_MODE, md(1'b1, 1'b0, 2'h0, 2'h0, codes[i]));
            wr(`TCS_OFF_CTRL, 32'h4);
         end
         exp = nxt(exp, codes[i]);
         tick(6);
         chk(line_b_o, exp);
         rdr(`TCS_OFF_STATUS);
         chk(rd[`TCS_ST_LINE_B], exp);
         if (use_ext) chk(rd[`TCS_ST_EXT_TRIG], 1'b1);
      end
      rdr(`TCS_OFF_STATUS);
      chk(rd[`TCS_ST_EXT_TRIG], 1'b0);
      chk(line_b_oe, 1'b1);
      chk(line_a_oe, 1'b1);
   endtask

   // counting with compares a=2 b=4 c=8, period restart on c
   task automatic t_match();
      logic [1:0] codes [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
      logic exp, prev;
      int n;
      wr(`TCS_OFF_PER_C, 32'h8);
      wr(`TCS_OFF_LAT_A, 32'h2);
      wr(`TCS_OFF_LAT_B, 32'h4);
      exp = line_b_o;
      foreach (codes[i]) begin
         wr(`TCS_OFF_MODE, md(1'b1, 1'b1, codes[i], 2'h0, 2'h0));
         wr(`TCS_OFF_CTRL, 32'h1);
         n = 0;
         prev = line_b_o;
         repeat (40) begin
            @(posedge aclk);
            if (line_b_o !== prev) n++;
            prev = line_b_o;
         end
         exp = nxt(exp, codes[i]);
         if (codes[i] == 2'h3) chk(n >= 2, 1'b1);
         else chk(line_b_o, exp);
         rdr(`TCS_OFF_STATUS);
         chk(rd & 32'h0001_001C, 32'h0001_001C);
         wr(`TCS_OFF_CTRL, 32'h2);
      end
      wr(`TCS_OFF_PER_C, 32'h8000);
      wr(`TCS_OFF_LAT_A, 32'h9000);
      wr(`TCS_OFF_LAT_B, 32'h9000);
      rdr(`TCS_OFF_STATUS);
      rdr(`TCS_OFF_STATUS);
      chk(rd & 32'h0001_001C, 32'h0);
      chk(rd[`TCS_ST_LINE_A], line_a_o);
   endtask

   // capture loads from line a edges, mirrors of sensed pins
   task automatic t_capture();
      wr(`TCS_OFF_MODE, md(1'b0, 1'b0, 2'h0, 2'h0, 2'h0));
      wr(`TCS_OFF_CTRL, 32'h1);
      rdr(`TCS_OFF_STATUS);
      chk({line_a_oe, line_b_oe}, 32'h0);
      line_a_i <= 1'b1;
      tick(8);
      rdr(`TCS_OFF_STATUS);
      chk(rd & 32'h0006_0062, 32'h0002_0020);
      line_a_i <= 1'b0;
      line_b_i <= 1'b1;
      tick(8);
      rdr(`TCS_OFF_STATUS);
      chk(rd & 32'h0006_0062, 32'h0004_0040);
      line_a_i <= 1'b1;
      tick(8);
      rdr(`TCS_OFF_STATUS);
      chk(rd[`TCS_ST_OVERWRITE], 1'b1);
      rdr(`TCS_OFF_LAT_A);
      chk(rd[31:16], 16'h0);
      line_a_i <= 1'b0;
      tick(8);
      wr(`TCS_OFF_MODE, md(1'b1, 1'b0, 2'h0, 2'h0, 2'h0));
      rdr(`TCS_OFF_STATUS);
      chk(rd & 32'h62, 32'h0);
   endtask

   // free run across the 16-bit wrap
   task automatic t_wrap();
      logic [31:0] first;
      wr(`TCS_OFF_MODE, md(1'b0, 1'b0, 2'h0, 2'h0, 2'h0));
      rdr(`TCS_OFF_COUNT);
      first = rd;
      rdr(`TCS_OFF_COUNT);
      chk(rd != first, 1'b1);
      chk(rd[31:16], 16'h0);
      rdr(`TCS_OFF_STATUS);
      tick(65540);
      // stop first so no second wrap can land between the two reads
      wr(`TCS_OFF_CTRL, 32'h2);
      rdr(`TCS_OFF_STATUS);
      chk(rd[`TCS_ST_WRAP], 1'b1);
      rdr(`TCS_OFF_STATUS);
      chk(rd[`TCS_ST_WRAP], 1'b0);
   endtask

   // watchdog against a hang
   initial begin
      #(20 * 90000);
      fail_count++;
      report_and_stop();
   end

   // reset, then the scenarios
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} <= '0;
      {awaddr, araddr, wdata, line_a_i, line_b_i, ext_ev} <= '0;
      tick(3);
      aresetn <= 1'b1;
      tick(2);
      t_regs();
      t_trig(1'b0);
      t_trig(1'b1);
      t_match();
      t_capture();
      t_wrap();
      report_and_stop();
   end
endmodule // tb
